// [rtl/ulmc_pkg.sv]
// Function
// - selector 10 uses fixed tables; 11 uses programmable trigger register.
// - format bits 1:0 choose 5, 6, 7 or 8 data bits.
// - format bit 2 gives one, one and half, or two stop bits.
// - format bit 3 enables parity generation and checking.
// - format bit 4 picks odd (0) or even (1) parity.
// - format bit 5 forces parity to inverse of bit 4.
// - format bit 6 holds transmit output at space outside loopback.
// - format bit 7 redirects data addresses to divisor latches.
// - modem bit 0 drives active-low DTR inversely outside loopback.
// - modem bit 1 drives active-low RTS unless loopback or auto flow owns it.
// - modem bit 2 drives first aux output inversely; loops to ring indicator.
// - interrupt output floats when select pin and bit 3 both 0.
// - modem bit 3 sets second aux output inversely, in and outside loopback.
// - modem bit 4 enables internal loopback.
// - modem bit 5 lets any received character resume transmit.
// - resume-on-any still stores characters except flow characters when software flow is on.
// - loopback status bits reflect modem bits 1, 0, 2, 3.
package ulmc_pkg;
   localparam logic [7:0] ADDR_LFC = 8'h00;
   localparam logic [7:0] ADDR_MLC = 8'h04;
   localparam logic [7:0] ADDR_FSEL = 8'h08;
   localparam logic [7:0] ADDR_FSET = 8'h0c;
   localparam logic [7:0] ADDR_TRIG = 8'h10;
   localparam logic [7:0] ADDR_ENH = 8'h14;
   localparam logic [7:0] ADDR_STAT = 8'h18;
   localparam logic [7:0] ADDR_LEVEL = 8'h1c;
   localparam logic [7:0] ADDR_RXC = 8'h20;
   localparam logic [7:0] LFC_RST = 8'h00;
   localparam logic [7:0] MLC_RST = 8'h00;
   localparam logic [7:0] FSEL_RST = 8'h00;
   localparam logic [7:0] FSET_RST = 8'h00;
   localparam logic [7:0] TRIG_RST = 8'h00;
   localparam logic [7:0] ENH_RST = 8'h00;
   localparam logic [7:0] XON_CHAR = 8'h11;
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam int LFC_BREAK = 6;
   localparam int LFC_DLAB = 7;
   localparam int MLC_LOOP = 4;
   localparam int MLC_XANY = 5;
   localparam int ENH_AUTORTS = 6;
   localparam int ENH_SWFLOW = 3;
   localparam int FSEL_TRGSEL = 7;
   localparam logic [1:0] OKAY = 2'b00;
   localparam logic [1:0] SLVERR = 2'b10;
   // stop length in half-bit units
   localparam logic [2:0] STOP_ONE = 3'h2;
   localparam logic [2:0] STOP_ONEHALF = 3'h3;
   localparam logic [2:0] STOP_TWO = 3'h4;
endpackage : ulmc_pkg

// [rtl/ulmc_top.sv]
`timescale 1ns/1ps
module ulmc_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic tx_serial_core,
   input wire logic auto_rts_n,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic cd_n,
   input wire logic irq_mode_select_pin,
   input wire logic irq_core,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   output logic tx_serial,
   output logic dtr_n,
   output logic rts_n,
   output logic irq_out,
   output logic irq_oe,
   output logic divisor_select,
   output logic [1:0] char_len_sel,
   output logic [2:0] stop_half_bits,
   output logic parity_enable,
   output logic parity_even,
   output logic parity_forced,
   output logic parity_force_val,
   output logic loopback,
   output logic aux_out_one,
   output logic aux_out_two,
   output logic [5:0] rx_trigger,
   output logic [5:0] tx_trigger,
   output logic [7:0] trig_rx_level,
   output logic [7:0] trig_tx_level,
   output logic tx_resume,
   output logic rx_store
);
   import ulmc_pkg::*;

   logic [7:0] lfc_q, lfc_d, mlc_q, mlc_d, fsel_q, fsel_d, fset_q, fset_d;
   logic [7:0] enh_q, enh_d, trgr_q, trgr_d, trgt_q, trgt_d, rxc_q, rxc_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic [5:0] rxt_q, rxt_d, txt_q, txt_d;
   logic [7:0] out_q, out_d;
   logic [7:0] msr;
   logic [2:0] stop_q, stop_d;
   logic [3:0] ws_q, ws_d;
   logic awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d, irq_q;
   logic [1:0] par_q, par_d;

   function automatic logic known(input logic [7:0] a);
      known = (a == ADDR_LFC) || (a == ADDR_MLC) || (a == ADDR_FSEL)
         || (a == ADDR_FSET) || (a == ADDR_TRIG) || (a == ADDR_ENH)
         || (a == ADDR_STAT) || (a == ADDR_LEVEL) || (a == ADDR_RXC);
   endfunction : known

   function automatic logic writable(input logic [7:0] a);
      writable = known(a) && (a != ADDR_STAT) && (a != ADDR_LEVEL)
         && (a != ADDR_RXC);
   endfunction : writable

   // modem status as seen by software
   always_comb
   begin
      msr = 8'h00;
      if (mlc_q[MLC_LOOP])
         msr[7:4] = {mlc_q[3], mlc_q[2], mlc_q[0], mlc_q[1]};
      else
         msr[7:4] = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
   end

   always_comb
   begin
      logic do_w;
      do_w = 1'b0;
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      lfc_d = lfc_q;
      mlc_d = mlc_q;
      fsel_d = fsel_q;
      fset_d = fset_q;
      enh_d = enh_q;
      trgr_d = trgr_q;
      trgt_d = trgt_q;
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_d = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (aw_q && w_q && !bv_q)
      begin
         // a write without the low byte lane leaves the register alone
         do_w = writable(awa_q) && ws_q[0];
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = writable(awa_q) ? OKAY : SLVERR;
      end
      if (bv_q && s_axi_bready)
         bv_d = 1'b0;
      awrdy_d = !aw_d && !bv_d;
      wrdy_d = !w_d && !bv_d;
      if (do_w)
      begin
         unique case (awa_q)
            ADDR_LFC: lfc_d = wd_q[7:0];
            ADDR_MLC: mlc_d = wd_q[7:0];
            ADDR_FSEL: fsel_d = wd_q[7:0];
            ADDR_FSET: fset_d = wd_q[7:0];
            ADDR_ENH: enh_d = wd_q[7:0];
            // selector register bit 7 steers trigger writes to rx or tx
            ADDR_TRIG:
               if (fsel_q[FSEL_TRGSEL])
                  trgt_d = wd_q[7:0];
               else
                  trgr_d = wd_q[7:0];
            default: lfc_d = lfc_q;
         endcase
      end
   end

   // strobe byte lane kept with data
   always_comb
   begin
      ws_d = ws_q;
      if (s_axi_wvalid && s_axi_wready)
         ws_d = s_axi_wstrb;
   end

   always_comb
   begin
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_axi_arvalid && s_axi_arready)
      begin
         rv_d = 1'b1;
         rr_d = known(s_axi_araddr) ? OKAY : SLVERR;
         unique case (s_axi_araddr)
            ADDR_LFC: rd_d = {24'h0, lfc_q};
            ADDR_MLC: rd_d = {24'h0, mlc_q};
            ADDR_FSEL: rd_d = {24'h0, fsel_q};
            ADDR_FSET: rd_d = {24'h0, fset_q};
            ADDR_TRIG: rd_d = {16'h0, trgt_q, trgr_q};
            ADDR_ENH: rd_d = {24'h0, enh_q};
            ADDR_STAT: rd_d = {24'h0, msr};
            ADDR_LEVEL: rd_d = {20'h0, txt_q[5:0], rxt_q[5:0]};
            ADDR_RXC: rd_d = {24'h0, rxc_q};
            default: rd_d = 32'h0;
         endcase
      end
      else if (rv_q && s_axi_rready)
         rv_d = 1'b0;
      arrdy_d = !rv_d;
   end

   // trigger tables and format decode
   always_comb
   begin
      rxt_d = 6'h01;
      txt_d = 6'h01;
      // fixed table when selector is 10
      if (fsel_q[5:4] == 2'b10)
      begin
         unique case (fset_q[5:4])
            2'b00: txt_d = 6'd8;
            2'b01: txt_d = 6'd16;
            2'b10: txt_d = 6'd32;
            2'b11: txt_d = 6'd56;
         endcase
         unique case (fset_q[7:6])
            2'b00: rxt_d = 6'd8;
            2'b01: rxt_d = 6'd16;
            2'b10: rxt_d = 6'd56;
            2'b11: rxt_d = 6'd60;
         endcase
      end
      if (!lfc_q[2])
         stop_d = STOP_ONE;
      else if (lfc_q[1:0] == 2'b00)
         stop_d = STOP_ONEHALF;
      else
         stop_d = STOP_TWO;
      par_d = {lfc_q[3] & lfc_q[5], ~lfc_q[4]};
   end

   always_comb
   begin
      logic lp;
      logic flowc;
      lp = mlc_q[MLC_LOOP];
      flowc = enh_q[ENH_SWFLOW]
         && ((rx_char == XON_CHAR) || (rx_char == XOFF_CHAR));
      out_d = 8'h00;
      // break forces space; loopback idles mark
      out_d[0] = lp ? 1'b1 : (lfc_q[LFC_BREAK] ? 1'b0 : tx_serial_core);
      out_d[1] = lp ? 1'b1 : ~mlc_q[0];
      out_d[2] = lp ? 1'b1
         : (enh_q[ENH_AUTORTS] ? auto_rts_n : ~mlc_q[1]);
      out_d[3] = irq_mode_select_pin | mlc_q[3];
      // bit 2 drives aux one inverse; aux two inverse
      out_d[4] = ~mlc_q[2];
      out_d[5] = ~mlc_q[3];
      out_d[6] = rx_char_valid && (mlc_q[MLC_XANY] || rx_char == XON_CHAR);
      out_d[7] = rx_char_valid && !flowc;
      rxc_d = rxc_q + {7'h0, out_d[7]};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0;
         ws_q <= 4'h0;
         bv_q <= 1'b0;
         br_q <= OKAY;
         rv_q <= 1'b0;
         rd_q <= 32'h0;
         rr_q <= OKAY;
         lfc_q <= LFC_RST;
         mlc_q <= MLC_RST;
         fsel_q <= FSEL_RST;
         fset_q <= FSET_RST;
         enh_q <= ENH_RST;
         trgr_q <= TRIG_RST;
         trgt_q <= TRIG_RST;
         rxt_q <= 6'h01;
         txt_q <= 6'h01;
         stop_q <= STOP_ONE;
         out_q <= 8'h37;
         rxc_q <= 8'h00;
         awrdy_q <= 1'b1;
         wrdy_q <= 1'b1;
         arrdy_q <= 1'b1;
         irq_q <= 1'b0;
         par_q <= 2'b01;
      end
      else
      begin
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         lfc_q <= lfc_d;
         mlc_q <= mlc_d;
         fsel_q <= fsel_d;
         fset_q <= fset_d;
         enh_q <= enh_d;
         trgr_q <= trgr_d;
         trgt_q <= trgt_d;
         rxt_q <= rxt_d;
         txt_q <= txt_d;
         stop_q <= stop_d;
         out_q <= out_d;
         rxc_q <= rxc_d;
         awrdy_q <= awrdy_d;
         wrdy_q <= wrdy_d;
         arrdy_q <= arrdy_d;
         irq_q <= irq_core;
         par_q <= par_d;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;
   assign tx_serial = out_q[0];
   assign dtr_n = out_q[1];
   assign rts_n = out_q[2];
   assign irq_oe = out_q[3];
   assign irq_out = irq_q;
   assign aux_out_one = out_q[4];
   assign aux_out_two = out_q[5];
   assign tx_resume = out_q[6];
   assign rx_store = out_q[7];
   assign divisor_select = lfc_q[LFC_DLAB];
   assign char_len_sel = lfc_q[1:0];
   assign stop_half_bits = stop_q;
   // parity enable; odd or even; forced value
   assign parity_enable = lfc_q[3];
   assign parity_even = lfc_q[4];
   assign parity_forced = par_q[1];
   assign parity_force_val = par_q[0];
   assign loopback = mlc_q[MLC_LOOP];
   assign rx_trigger = rxt_q;
   assign tx_trigger = txt_q;
   assign trig_rx_level = trgr_q;
   assign trig_tx_level = trgt_q;

   // break set outside loopback, still set one edge later
   sequence s_break_held;
      lfc_q[LFC_BREAK] && !mlc_q[MLC_LOOP] ##1 lfc_q[LFC_BREAK];
   endsequence : s_break_held

   a_break_space: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_break_held |-> !tx_serial)
      else $error("break did not hold space");
   a_dtr_inverse: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !$past(mlc_q[MLC_LOOP]) |-> dtr_n == !$past(mlc_q[0]))
      else $error("dtr not inverse");
   a_irq_enable: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(irq_mode_select_pin) |-> irq_oe)
      else $error("irq not driven");
   a_loop_mark: assert property (
      @(posedge aclk) disable iff (!aresetn)
      $past(mlc_q[MLC_LOOP]) |-> tx_serial && rts_n && dtr_n)
      else $error("loopback outputs active");
   a_aux_two: assert property (
      @(posedge aclk) disable iff (!aresetn)
      aux_out_two == !$past(mlc_q[3]))
      else $error("aux two wrong");
   a_flow_drop: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rx_char_valid && enh_q[ENH_SWFLOW] && rx_char == XOFF_CHAR
      |=> !rx_store)
      else $error("flow char stored");
   a_any_resume: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rx_char_valid && mlc_q[MLC_XANY] |=> tx_resume)
      else $error("no resume");
   a_trig_tbl: assert property (
      @(posedge aclk) disable iff (!aresetn)
      fsel_q[5:4] == 2'b10 && fset_q[7:6] == 2'b11 |=> rx_trigger == 6'd60)
      else $error("rx trigger wrong");
endmodule : ulmc_top

// [sim/ulmc_remote.sv]
`timescale 1ns/1ps
module ulmc_remote
(
   input wire logic aclk,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic cd_n,
   output logic rx_char_valid,
   output logic [7:0] rx_char
);
   initial
   begin
      {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
      rx_char_valid = 1'b0;
      rx_char = 8'h00;
   end
   task set_pins(input logic [3:0] p);
      @(posedge aclk);
      {cd_n, ri_n, dsr_n, cts_n} <= p;
   endtask : set_pins
   // one received character as a single-cycle strobe, then inverted data
   task send_char(input logic [7:0] c);
      @(posedge aclk);
      rx_char_valid <= 1'b1;
      rx_char <= c;
      @(posedge aclk);
      rx_char_valid <= 1'b0;
      rx_char <= ~c;
   endtask : send_char
endmodule : ulmc_remote

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   import ulmc_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, tx_serial_core;
   logic auto_rts_n, cts_n, dsr_n, ri_n, cd_n, irq_mode_select_pin;
   logic irq_core, rx_char_valid, tx_serial, dtr_n, rts_n, irq_out, irq_oe;
   logic divisor_select, parity_enable, parity_even, parity_forced;
   logic parity_force_val, loopback, aux_out_one, aux_out_two;
   logic tx_resume, rx_store;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rx_char;
   logic [7:0] trig_rx_level, trig_tx_level;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, char_len_sel, r;
   logic [2:0] stop_half_bits;
   logic [5:0] rx_trigger, tx_trigger;
   int n_mismatch, n_checks, n_res, n_sto;
   int rx_t[4] = '{8, 16, 56, 60};
   int tx_t[4] = '{8, 16, 32, 56};
   ulmc_top uut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .tx_serial_core(tx_serial_core),
      .auto_rts_n(auto_rts_n), .cts_n(cts_n), .dsr_n(dsr_n),
      .ri_n(ri_n), .cd_n(cd_n), .irq_mode_select_pin(irq_mode_select_pin),
      .irq_core(irq_core), .rx_char_valid(rx_char_valid),
      .rx_char(rx_char), .tx_serial(tx_serial), .dtr_n(dtr_n),
      .rts_n(rts_n), .irq_out(irq_out), .irq_oe(irq_oe),
      .divisor_select(divisor_select), .char_len_sel(char_len_sel),
      .stop_half_bits(stop_half_bits), .parity_enable(parity_enable),
      .parity_even(parity_even), .parity_forced(parity_forced),
      .parity_force_val(parity_force_val), .loopback(loopback),
      .aux_out_one(aux_out_one), .aux_out_two(aux_out_two),
      .rx_trigger(rx_trigger), .tx_trigger(tx_trigger),
      .trig_rx_level(trig_rx_level), .trig_tx_level(trig_tx_level),
      .tx_resume(tx_resume), .rx_store(rx_store)
   );
   ulmc_remote rem
   (
      .aclk(aclk), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
      .cd_n(cd_n), .rx_char_valid(rx_char_valid), .rx_char(rx_char)
   );
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      n_res += tx_resume;
      n_sto += rx_store;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   // write, then let the register and its outputs land
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      r = s_axi_bresp;
      repeat (2) @(posedge aclk);
      #1;
   endtask : wr
   task rdr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      r = s_axi_rresp;
      #1;
   endtask : rdr
   task t_format;
      for (int i = 0; i < 64; i++)
      begin
         wr(ADDR_LFC, i[7:0]);
         chk(char_len_sel, i[1:0]);
         chk(stop_half_bits, !i[2] ? STOP_ONE : i[1:0] == 0 ? STOP_ONEHALF : STOP_TWO);
         chk(parity_enable, i[3]);
         chk(parity_even, i[4]);
         chk(parity_forced, i[3] & i[5]);
         if (i[3] && i[5])
            chk(parity_force_val, !i[4]);
      end
      $display("format done");
   endtask : t_format
   task t_break;
      wr(ADDR_LFC, 8'hc0);
      for (int k = 0; k < 4; k++)
      begin
         @(posedge aclk);
         tx_serial_core <= k[0];
         #1;
         chk(tx_serial, 1'b0);
      end
      chk(divisor_select, 1'b1);
      tx_serial_core <= 1'b0;
      wr(ADDR_LFC, 8'h00);
      chk(tx_serial, 1'b0);
      chk(divisor_select, 1'b0);
      @(posedge aclk);
      tx_serial_core <= 1'b1;
      repeat (2) @(posedge aclk);
      #1;
      chk(tx_serial, 1'b1);
      $display("break done");
   endtask : t_break
   task t_modem;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge aclk);
         irq_mode_select_pin <= i[1];
         irq_core <= i[0];
         wr(ADDR_MLC, {4'h0, i[0], 1'b0, i[1:0]});
         chk(dtr_n, !i[0]);
         chk(rts_n, !i[1]);
         chk(irq_oe, i[0] | i[1]);
         chk(irq_out, i[0]);
      end
      // board keeps the select low for the other bus style
      irq_mode_select_pin <= 1'b0;
      wr(ADDR_ENH, 8'h40);
      chk(rts_n, 1'b1);
      auto_rts_n <= 1'b0;
      wr(ADDR_MLC, 8'h00);
      chk(rts_n, 1'b0);
      auto_rts_n <= 1'b1;
      wr(ADDR_ENH, 8'h00);
      $display("modem done");
   endtask : t_modem
   task t_loop;
      rem.set_pins(4'b0101);
      tx_serial_core <= 1'b0;
      wr(ADDR_MLC, 8'h00);
      rdr(ADDR_STAT);
      chk(rd[7:4], 4'b1010);
      for (int i = 0; i < 16; i++)
      begin
         wr(ADDR_MLC, {4'h1, i[3:0]});
         rdr(ADDR_STAT);
         chk(rd[7:4], {i[3], i[2], i[0], i[1]});
         chk(aux_out_two, !i[3]);
         chk(aux_out_one, !i[2]);
         chk({tx_serial, dtr_n, rts_n}, 3'b111);
         chk(loopback, 1'b1);
      end
      wr(ADDR_MLC, 8'h00);
      chk(loopback, 1'b0);
      $display("loopback done");
   endtask : t_loop
   task t_trig;
      wr(ADDR_ENH, 8'h10);
      wr(ADDR_FSEL, 8'h20);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_FSET, {i[1:0], 2'(3 - i), 4'h1});
         chk(rx_trigger, rx_t[i]);
         chk(tx_trigger, tx_t[3 - i]);
      end
      wr(ADDR_FSEL, 8'h30);
      wr(ADDR_TRIG, 8'h2a);
      wr(ADDR_FSEL, 8'hb0);
      wr(ADDR_TRIG, 8'h45);
      chk(trig_rx_level, 8'h2a);
      chk(trig_tx_level, 8'h45);
      $display("trigger done");
   endtask : t_trig
   task xcase(input logic [7:0] m, input logic [7:0] c, input int er, es);
      wr(ADDR_MLC, m);
      n_res = 0;
      n_sto = 0;
      rem.send_char(c);
      repeat (3) @(posedge aclk);
      #1;
      chk(n_res, er);
      chk(n_sto, es);
   endtask : xcase
   task t_xany;
      wr(ADDR_ENH, 8'h08);
      xcase(8'h20, 8'h41, 1, 1);
      xcase(8'h20, XON_CHAR, 1, 0);
      xcase(8'h20, XOFF_CHAR, 1, 0);
      xcase(8'h00, 8'h41, 0, 1);
      xcase(8'h00, XON_CHAR, 1, 0);
      // without software flow a flow character is plain data
      wr(ADDR_ENH, 8'h00);
      xcase(8'h20, XON_CHAR, 1, 1);
      wr(8'h40, 8'h00);
      chk(r, SLVERR);
      wr(ADDR_STAT, 8'h00);
      chk(r, SLVERR);
      rdr(8'h40);
      chk(r, SLVERR);
      // low byte lane off: register keeps its value
      wr(ADDR_MLC, 8'h0b);
      s_axi_wstrb <= 4'he;
      wr(ADDR_MLC, 8'h05);
      s_axi_wstrb <= 4'hf;
      rdr(ADDR_MLC);
      chk(rd, 32'h0000000b);
      $display("resume done");
   endtask : t_xany
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   initial
   begin
      #200000;
      n_mismatch++;
      end_of_test();
   end
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, irq_mode_select_pin, irq_core} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {tx_serial_core, auto_rts_n} = 2'b11;
      s_axi_wstrb = 4'hf;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdr(ADDR_LFC);
      chk(rd, 32'h0);
      chk({tx_serial, dtr_n, rts_n, irq_oe}, 4'b1110);
      t_format();
      t_break();
      t_modem();
      t_loop();
      t_trig();
      t_xany();
      end_of_test();
   end
endmodule : tb_top
